// ==== pkg/pin_select_led_settle_count_ram_ptr_map.vh ====
// Offsets, fields, reset values and timing of the pin/LED/RAM-pointer group
// Operation
// - LED settle wait is count times 1024 us
// - Interrupt pin source chosen by bits 6:4
// - Bit 3 inverts the interrupt pin
// - General pin source chosen by bits 2:0
// - Offset plus window index addresses RAM, page
// - Offsets 0x0C-0x0F pick mux config A-D
// - Offsets 0x10/0x11 pick analog setup AB/CD
// - Offset 0x12 picks compensation DAC, others reserved
// - Invert bit flips general pin both directions
// - Drive enable bit drives the selected general pin source; source code 0 gives software level bit 1
// - Done flag routable once measurement finished
// - Active flag routable while measurement runs
`ifndef PIN_SELECT_LED_SETTLE_COUNT_RAM_PTR_MAP_VH
`define PIN_SELECT_LED_SETTLE_COUNT_RAM_PTR_MAP_VH

// Register addresses
`define ADDR_LED_SETTLE_DELAY 8'h3D
`define ADDR_OUTPUT_PIN_SOURCE_MAP 8'h3E
`define ADDR_CONFIG_RAM_POINTER 8'h6A
`define ADDR_GENERAL_PIN_CONTROL 8'h6B
// Base of the 32-entry indirect RAM window
`define ADDR_RAM_WINDOW_BASE 8'h40
`define RAM_WINDOW_SIZE 8'h20

// Reset values
`define RST_LED_SETTLE_DELAY 8'h00
`define RST_OUTPUT_PIN_SOURCE_MAP 8'h00
`define RST_CONFIG_RAM_POINTER 8'h00
`define RST_GENERAL_PIN_CONTROL 8'h00

// Source map fields
`define IRQ_SEL_MSB 6
`define IRQ_SEL_LSB 4
`define IRQ_INVERT_BIT 3
`define AUX_SEL_MSB 2
`define AUX_SEL_LSB 0
// Source codes
`define SRC_FUNCTION 3'h0
`define SRC_MEAS_DONE 3'h1
`define SRC_MEAS_ACTIVE 3'h2
`define SRC_ILLUM 3'h3

// RAM pointer fields
`define SECOND_RAM_PAGE_BIT 7
`define RAM_OFFSET_MSB 4
`define RAM_OFFSET_LSB 0
// RAM locations of interest
`define LOC_SENSOR_MUX_A 5'h0C
`define LOC_SENSOR_MUX_D 5'h0F
`define LOC_ANALOG_SETUP_AB 5'h10
`define LOC_ANALOG_SETUP_CD 5'h11
`define LOC_COMP_DAC 5'h12

// General pin control fields
`define AUX_INVERT_BIT 3
`define AUX_DRIVE_ENABLE_BIT 2
`define AUX_OUT_LEVEL_BIT 1
`define AUX_IN_LEVEL_BIT 0

// Timing
`define CLOCK_FREQ_MHZ 10
`define LED_SETTLE_UNIT_US 1024
`define LED_SETTLE_UNIT_CYCLES (`LED_SETTLE_UNIT_US * `CLOCK_FREQ_MHZ)

`endif

// ==== src/pin_source_mux.v ====
// Output pin source selector with polarity inversion
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_led_settle_count_ram_ptr_map.vh"

module pin_source_mux (
  input wire [2:0] sourceSel,
  input wire invertPin,
  input wire functionSrc,
  input wire measDoneSrc,
  input wire measActiveSrc,
  input wire illumSrc,
  output reg pinValue
);

  // Selected source before polarity
  reg picked;

  // Reserved codes give a quiet low before inversion
  always @* begin
    picked = 1'b0;
    case (sourceSel)
      `SRC_FUNCTION: picked = functionSrc;
      `SRC_MEAS_DONE: picked = measDoneSrc;
      `SRC_MEAS_ACTIVE: picked = measActiveSrc;
      `SRC_ILLUM: picked = illumSrc;
      default: picked = 1'b0;
    endcase
    // Inversion after selection
    pinValue = picked ^ invertPin;
  end

endmodule
`default_nettype wire

// ==== src/led_settle_timer.v ====
// LED settle wait timer counted in 1024 us units
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_led_settle_count_ram_ptr_map.vh"

module led_settle_timer #(
  parameter UNIT_CYCLES = `LED_SETTLE_UNIT_CYCLES,
  parameter DIV_WIDTH = 14
) (
  input wire clock,
  input wire reset,
  input wire startPulse,
  input wire abortWait,
  input wire [7:0] settleCount,
  output reg settleBusy,
  output reg settleDone
);

  // Last divider state of one unit
  localparam integer DIV_LAST_FULL = UNIT_CYCLES - 1;
  // Cut to the divider width; DIV_WIDTH must hold UNIT_CYCLES-1
  localparam [DIV_WIDTH-1:0] DIV_LAST = DIV_LAST_FULL[DIV_WIDTH-1:0];

  // Divider inside one unit
  reg [DIV_WIDTH-1:0] divCount;
  // Units still to wait
  reg [7:0] unitsLeft;
  // One-cycle enable at the end of each unit
  wire unitTick;

  assign unitTick = settleBusy && (divCount == DIV_LAST);

  // Count is latched at start, so a later write waits for the next LED turn-on
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      divCount <= {DIV_WIDTH{1'b0}};
      unitsLeft <= 8'h00;
      settleBusy <= 1'b0;
      settleDone <= 1'b0;
    end else begin
      settleDone <= 1'b0;
      if (startPulse) begin
        divCount <= {DIV_WIDTH{1'b0}};
        unitsLeft <= settleCount;
        // Zero count means no wait at all
        if (settleCount == 8'h00) begin
          settleBusy <= 1'b0;
          settleDone <= 1'b1;
        end else begin
          settleBusy <= 1'b1;
        end
      end else if (abortWait) begin
        // LED went off before the wait ended
        settleBusy <= 1'b0;
        divCount <= {DIV_WIDTH{1'b0}};
      end else if (unitTick) begin
        divCount <= {DIV_WIDTH{1'b0}};
        unitsLeft <= unitsLeft - 8'h01;
        if (unitsLeft == 8'h01) begin
          settleBusy <= 1'b0;
          settleDone <= 1'b1;
        end
      end else if (settleBusy) begin
        divCount <= divCount + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== src/pin_select_led_settle_count_ram_ptr.v ====
// Pin map, LED settle delay, RAM pointer and general pin registers
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_led_settle_count_ram_ptr_map.vh"

module pin_select_led_settle_count_ram_ptr #(
  parameter LED_UNIT_CYCLES = `LED_SETTLE_UNIT_CYCLES,
  parameter LED_DIV_WIDTH = 14
) (
  input wire clock,
  input wire reset,
  // Internal register port from the serial slave
  input wire [7:0] regAddr,
  input wire regWrEn,
  input wire [7:0] regWrData,
  input wire regRdEn,
  output reg [7:0] regRdData,
  output reg regRdHit,
  // Measurement engine status, same clock
  input wire irqRequest,
  input wire measDoneFlag,
  input wire measActiveFlag,
  input wire illumActive,
  // LED settle handshake
  output reg ledSettleBusy,
  output reg ledSettleDone,
  // Output pins
  output reg irqOutPin,
  input wire auxPinIn,
  output reg auxPinOut,
  output reg auxPinDriveEnN,
  // Indirect configuration RAM access
  output reg ramWrEn,
  output reg ramRdEn,
  output reg [4:0] ramLocation,
  output reg secondRamPage,
  output reg [7:0] ramWrData,
  output reg [3:0] sensorMuxCfgSel,
  output reg [1:0] analogSetupCfgSel,
  output reg compensationDacCfgSel,
  output reg ramReservedSel
);

  // Register storage
  reg [7:0] ledSettleDelay_reg;
  reg [7:0] outputPinSourceMap_reg;
  reg [7:0] configRamPointer_reg;
  // Only bits 3:1 are storage; bit 0 is the live pin
  reg [3:1] generalPinControl_reg;
  // Full-byte reset value, sliced to the stored bits
  localparam [7:0] PIN_CONTROL_RESET = `RST_GENERAL_PIN_CONTROL;

  // Pin synchroniser stages
  reg auxSyncA_reg;
  reg auxSyncB_reg;

  // Previous LED state for turn-on detect
  reg illumPrev_reg;

  // Address decode flags
  reg hitLedDelay;
  reg hitSourceMap;
  reg hitRamPointer;
  reg hitPinControl;
  reg hitWindow;

  // Read mux result
  reg [7:0] readValue_next;

  // Window index and target RAM location
  wire [7:0] windowDelta;
  wire [4:0] windowIndex;
  wire [4:0] targetLoc;

  // Field views
  wire [2:0] irqSel;
  wire irqInvert;
  wire [2:0] auxSel;
  wire auxInvert;
  wire auxDriveEnable;
  wire auxOutLevel;
  wire auxInLevel;

  // Mux results
  wire irqPinValue;
  wire auxPinValue;

  // LED turn-on and turn-off edges
  wire illumStart;
  wire illumStop;

  // Timer outputs
  wire timerBusy;
  wire timerDone;

  assign irqSel = outputPinSourceMap_reg[`IRQ_SEL_MSB:`IRQ_SEL_LSB];
  assign irqInvert = outputPinSourceMap_reg[`IRQ_INVERT_BIT];
  assign auxSel = outputPinSourceMap_reg[`AUX_SEL_MSB:`AUX_SEL_LSB];
  assign auxInvert = generalPinControl_reg[`AUX_INVERT_BIT];
  assign auxDriveEnable = generalPinControl_reg[`AUX_DRIVE_ENABLE_BIT];
  assign auxOutLevel = generalPinControl_reg[`AUX_OUT_LEVEL_BIT];

  // Sampled pin seen through the invert bit
  assign auxInLevel = auxSyncB_reg ^ auxInvert;

  // Window decode: distance from the window base
  assign windowDelta = regAddr - `ADDR_RAM_WINDOW_BASE;
  assign windowIndex = windowDelta[4:0];

  // Location wraps inside the 32-entry page
  assign targetLoc = configRamPointer_reg[`RAM_OFFSET_MSB:`RAM_OFFSET_LSB]
    + windowIndex;

  assign illumStart = illumActive && !illumPrev_reg;
  assign illumStop = !illumActive && illumPrev_reg;

  // Address decode, one match at most
  always @* begin
    hitLedDelay = 1'b0;
    hitSourceMap = 1'b0;
    hitRamPointer = 1'b0;
    hitPinControl = 1'b0;
    hitWindow = 1'b0;
    if (regAddr == `ADDR_LED_SETTLE_DELAY) begin
      hitLedDelay = 1'b1;
    end else if (regAddr == `ADDR_OUTPUT_PIN_SOURCE_MAP) begin
      hitSourceMap = 1'b1;
    end else if (regAddr == `ADDR_CONFIG_RAM_POINTER) begin
      hitRamPointer = 1'b1;
    end else if (regAddr == `ADDR_GENERAL_PIN_CONTROL) begin
      hitPinControl = 1'b1;
    end else if (windowDelta < `RAM_WINDOW_SIZE) begin
      // Data itself lives in the RAM, not here
      hitWindow = 1'b1;
    end
  end

  // Read value of the addressed register
  always @* begin
    readValue_next = 8'h00;
    if (hitLedDelay) begin
      readValue_next = ledSettleDelay_reg;
    end else if (hitSourceMap) begin
      // Bit 7 unused, reads zero
      readValue_next = {1'b0, outputPinSourceMap_reg[6:0]};
    end else if (hitRamPointer) begin
      // Bits 6:5 unused, read zero
      readValue_next = {configRamPointer_reg[7], 2'b00, configRamPointer_reg[4:0]};
    end else if (hitPinControl) begin
      readValue_next = {4'h0, generalPinControl_reg, auxInLevel};
    end
  end

  // Register writes; unused bits are not stored
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ledSettleDelay_reg <= `RST_LED_SETTLE_DELAY;
      outputPinSourceMap_reg <= `RST_OUTPUT_PIN_SOURCE_MAP;
      configRamPointer_reg <= `RST_CONFIG_RAM_POINTER;
      generalPinControl_reg <= PIN_CONTROL_RESET[3:1];
    end else if (regWrEn) begin
      if (hitLedDelay) begin
        ledSettleDelay_reg <= regWrData;
      end else if (hitSourceMap) begin
        outputPinSourceMap_reg <= {1'b0, regWrData[6:0]};
      end else if (hitRamPointer) begin
        configRamPointer_reg <= {regWrData[7], 2'b00, regWrData[4:0]};
      end else if (hitPinControl) begin
        // Bit 0 is read-only; the written value is dropped
        generalPinControl_reg <= regWrData[3:1];
      end
    end
  end

  // Read answer one cycle after the strobe
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      regRdData <= 8'h00;
      regRdHit <= 1'b0;
    end else begin
      regRdHit <= 1'b0;
      if (regRdEn) begin
        // Unmapped addresses answer zero with no hit
        regRdData <= readValue_next;
        regRdHit <= hitLedDelay | hitSourceMap | hitRamPointer | hitPinControl;
      end
    end
  end

  // Two-stage synchroniser for the general pin
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      auxSyncA_reg <= 1'b0;
      auxSyncB_reg <= 1'b0;
    end else begin
      auxSyncA_reg <= auxPinIn;
      auxSyncB_reg <= auxSyncA_reg;
    end
  end

  // LED state history
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      illumPrev_reg <= 1'b0;
    end else begin
      illumPrev_reg <= illumActive;
    end
  end

  // Settle timer, started on each LED turn-on
  led_settle_timer #(
    .UNIT_CYCLES(LED_UNIT_CYCLES),
    .DIV_WIDTH(LED_DIV_WIDTH)
  ) settleTimer (
    .clock(clock),
    .reset(reset),
    .startPulse(illumStart),
    .abortWait(illumStop),
    .settleCount(ledSettleDelay_reg),
    .settleBusy(timerBusy),
    .settleDone(timerDone)
  );

  // Interrupt pin source
  pin_source_mux irqMux (
    .sourceSel(irqSel),
    .invertPin(irqInvert),
    .functionSrc(irqRequest),
    .measDoneSrc(measDoneFlag),
    .measActiveSrc(measActiveFlag),
    .illumSrc(illumActive),
    .pinValue(irqPinValue)
  );

  // General pin source; its function is the software level
  pin_source_mux auxMux (
    .sourceSel(auxSel),
    .invertPin(auxInvert),
    .functionSrc(auxOutLevel),
    .measDoneSrc(measDoneFlag),
    .measActiveSrc(measActiveFlag),
    .illumSrc(illumActive),
    .pinValue(auxPinValue)
  );

  // Pin and handshake outputs registered for clean edges
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      irqOutPin <= 1'b0;
      auxPinOut <= 1'b0;
      auxPinDriveEnN <= 1'b1;
      ledSettleBusy <= 1'b0;
      ledSettleDone <= 1'b0;
    end else begin
      irqOutPin <= irqPinValue;
      auxPinOut <= auxPinValue;
      // Driver off unless software enables it
      auxPinDriveEnN <= !auxDriveEnable;
      ledSettleBusy <= timerBusy;
      ledSettleDone <= timerDone;
    end
  end

  // Indirect window access toward the configuration RAM
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ramWrEn <= 1'b0;
      ramRdEn <= 1'b0;
      ramLocation <= 5'h00;
      secondRamPage <= 1'b0;
      ramWrData <= 8'h00;
    end else begin
      ramWrEn <= regWrEn && hitWindow;
      ramRdEn <= regRdEn && hitWindow;
      if ((regWrEn || regRdEn) && hitWindow) begin
        // Pointer sampled before any same-cycle rewrite
        ramLocation <= targetLoc;
        secondRamPage <= configRamPointer_reg[`SECOND_RAM_PAGE_BIT];
        ramWrData <= regWrData;
      end
    end
  end

  // Meaning of the addressed location, held until the next access
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sensorMuxCfgSel <= 4'h0;
      analogSetupCfgSel <= 2'h0;
      compensationDacCfgSel <= 1'b0;
      ramReservedSel <= 1'b0;
    end else if ((regWrEn || regRdEn) && hitWindow) begin
      sensorMuxCfgSel <= 4'h0;
      analogSetupCfgSel <= 2'h0;
      compensationDacCfgSel <= 1'b0;
      ramReservedSel <= 1'b0;
      if (targetLoc >= `LOC_SENSOR_MUX_A && targetLoc <= `LOC_SENSOR_MUX_D) begin
        // One bit per integration cycle A..D
        sensorMuxCfgSel <= 4'h1 << targetLoc[1:0];
      end else if (targetLoc == `LOC_ANALOG_SETUP_AB) begin
        analogSetupCfgSel <= 2'h1;
      end else if (targetLoc == `LOC_ANALOG_SETUP_CD) begin
        analogSetupCfgSel <= 2'h2;
      end else if (targetLoc == `LOC_COMP_DAC) begin
        compensationDacCfgSel <= 1'b1;
      end else begin
        // Undefined locations flagged, access still passed on
        ramReservedSel <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== dv/register_host_model.sv ====
// Host model driving the internal register port of the group
`timescale 1ns/1ps
`default_nettype none
module register_host_model (
  input wire logic clock,
  output var logic [7:0] regAddr,
  output var logic regWrEn,
  output var logic [7:0] regWrData,
  output var logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdHit
);
  // Idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // Write strobe held until the taking edge, data inverted after release
  task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    regAddr = addr;
    regWrData = data;
    regWrEn = 1'b1;
    @(posedge clock);
    #1;
    regWrEn = 1'b0;
    regWrData = ~data;
  endtask
  // Read answer lands one edge after the strobe
  task automatic readReg(input logic [7:0] addr, output logic [7:0] data, output logic hit);
    @(posedge clock);
    #1;
    regAddr = addr;
    regRdEn = 1'b1;
    @(posedge clock);
    #1;
    data = regRdData;
    hit = regRdHit;
    regRdEn = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/pin_select_led_settle_count_ram_ptr_monitor.sv ====
// Concurrent checks on the pin map, settle delay, pointer and general pin group
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_led_settle_count_ram_ptr_map.vh"
module pin_select_led_settle_count_ram_ptr_monitor #(
  parameter LED_UNIT_CYCLES = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdHit,
  input wire logic irqRequest,
  input wire logic measDoneFlag,
  input wire logic measActiveFlag,
  input wire logic illumActive,
  input wire logic ledSettleBusy,
  input wire logic ledSettleDone,
  input wire logic irqOutPin,
  input wire logic auxPinOut,
  input wire logic auxPinDriveEnN,
  input wire logic ramWrEn,
  input wire logic ramRdEn,
  input wire logic [4:0] ramLocation,
  input wire logic secondRamPage,
  input wire logic [7:0] ramWrData,
  input wire logic [3:0] sensorMuxCfgSel,
  input wire logic [1:0] analogSetupCfgSel,
  input wire logic compensationDacCfgSel,
  input wire logic ramReservedSel
);
  logic [7:0] ledReg, mapReg, ptrReg, gpioReg; // Shadows of written bytes
  // Shadow registers follow every accepted write
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ledReg <= 8'h00;
      mapReg <= 8'h00;
      ptrReg <= 8'h00;
      gpioReg <= 8'h00;
    end else if (regWrEn) begin
      case (regAddr)
        `ADDR_LED_SETTLE_DELAY: ledReg <= regWrData;
        `ADDR_OUTPUT_PIN_SOURCE_MAP: mapReg <= regWrData;
        `ADDR_CONFIG_RAM_POINTER: ptrReg <= regWrData;
        `ADDR_GENERAL_PIN_CONTROL: gpioReg <= regWrData;
        default: ;
      endcase
    end
  end
  // Reserved codes give 0 before inversion
  function automatic logic pick(input logic [2:0] s, input logic f, input logic [3:0] v);
    pick = (s == 3'h0) ? f : (s < 3'h4) ? v[s[1:0]] : 1'b0;
  endfunction
  wire logic [3:0] srcs = {illumActive, measActiveFlag, measDoneFlag, 1'b0}; // Shared sources
  wire logic irqNext = pick(mapReg[6:4], irqRequest, srcs) ^ mapReg[3]; // Interrupt pin value
  wire logic auxNext = pick(mapReg[2:0], gpioReg[1], srcs) ^ gpioReg[3]; // General pin value
  wire logic [4:0] locNext = ptrReg[4:0] + regAddr[4:0]; // Window location, wraps at 32
  wire logic [3:0] muxExp = (ramLocation[4:2] == 3'b011) ? (4'h1 << ramLocation[1:0]) : 4'h0;
  wire logic resExp = (ramLocation < 5'h0C) || (ramLocation > 5'h12); // Undefined locations
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_settle_readback: assert property (regRdEn && regAddr == 8'h3D |=>
    regRdHit && regRdData == $past(ledReg)) else $error("settle delay readback wrong");
  chk_pointer_readback: assert property (regRdEn && regAddr == 8'h6A |=>
    regRdData == {$past(ptrReg[7]), 2'b00, $past(ptrReg[4:0])}) else $error("pointer readback wrong");
  chk_gpio_readback: assert property (regRdEn && regAddr == 8'h6B |=>
    regRdData[7:1] == {4'h0, $past(gpioReg[3:1])}) else $error("general pin readback wrong");
  chk_irq_route: assert property (!$past(reset) |-> irqOutPin == $past(irqNext))
    else $error("interrupt pin source wrong");
  chk_aux_route: assert property (!$past(reset) |-> auxPinOut == $past(auxNext))
    else $error("general pin source wrong");
  chk_drive_enable: assert property (!$past(reset) |-> auxPinDriveEnN == !$past(gpioReg[2]))
    else $error("general pin drive enable wrong");
  chk_window_write: assert property (regWrEn && regAddr[7:5] == 3'b010 |=> ramWrEn &&
    ramLocation == $past(locNext) && secondRamPage == $past(ptrReg[7]) &&
    ramWrData == $past(regWrData)) else $error("window write wrong");
  chk_select_decode: assert property (ramWrEn || ramRdEn |-> sensorMuxCfgSel == muxExp &&
    analogSetupCfgSel == {ramLocation == 5'h11, ramLocation == 5'h10} &&
    compensationDacCfgSel == (ramLocation == 5'h12) && ramReservedSel == resExp)
    else $error("location decode wrong");
  chk_settle_zero: assert property (!$past(reset) && $rose(illumActive) && ledReg == 8'h00 |->
    ##2 ledSettleDone && !ledSettleBusy) else $error("zero settle count not immediate");
endmodule
bind pin_select_led_settle_count_ram_ptr pin_select_led_settle_count_ram_ptr_monitor #(
  .LED_UNIT_CYCLES(LED_UNIT_CYCLES)) mon (.clock(clock), .reset(reset), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
  .regRdHit(regRdHit), .irqRequest(irqRequest), .measDoneFlag(measDoneFlag),
  .measActiveFlag(measActiveFlag), .illumActive(illumActive), .ledSettleBusy(ledSettleBusy),
  .ledSettleDone(ledSettleDone), .irqOutPin(irqOutPin), .auxPinOut(auxPinOut),
  .auxPinDriveEnN(auxPinDriveEnN), .ramWrEn(ramWrEn), .ramRdEn(ramRdEn),
  .ramLocation(ramLocation), .secondRamPage(secondRamPage), .ramWrData(ramWrData),
  .sensorMuxCfgSel(sensorMuxCfgSel), .analogSetupCfgSel(analogSetupCfgSel),
  .compensationDacCfgSel(compensationDacCfgSel), .ramReservedSel(ramReservedSel));
`default_nettype wire

// ==== dv/tb_pin_select_led_settle_count_ram_ptr.sv ====
// Self-checking bench for the pin map, settle delay, pointer and general pin group
`timescale 1ns/1ps
`default_nettype none
module tb_pin_select_led_settle_count_ram_ptr;
  localparam int UNIT = 4; // Short settle unit to keep the run brief
  logic clock, reset, irqRequest, measDoneFlag, measActiveFlag, illumActive, extLevel;
  logic [7:0] regAddr, regWrData, regRdData, ramWrData, d, e;
  logic regWrEn, regRdEn, regRdHit, ledSettleBusy, ledSettleDone, irqOutPin, auxPinOut;
  logic auxPinDriveEnN, ramWrEn, ramRdEn, secondRamPage, compSel, resSel, h, x, seen;
  logic [4:0] ramLocation;
  logic [3:0] muxSel, src;
  logic [1:0] anaSel;
  int failCount = 0;
  int nChecks = 0;
  int n;
  wire logic padLevel = auxPinDriveEnN ? extLevel : auxPinOut; // Pad seen by both parties
  pin_select_led_settle_count_ram_ptr #(.LED_UNIT_CYCLES(UNIT)) DUT (.clock(clock), .reset(reset),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdHit(regRdHit), .irqRequest(irqRequest),
    .measDoneFlag(measDoneFlag), .measActiveFlag(measActiveFlag), .illumActive(illumActive),
    .ledSettleBusy(ledSettleBusy), .ledSettleDone(ledSettleDone), .irqOutPin(irqOutPin),
    .auxPinIn(padLevel), .auxPinOut(auxPinOut), .auxPinDriveEnN(auxPinDriveEnN),
    .ramWrEn(ramWrEn), .ramRdEn(ramRdEn), .ramLocation(ramLocation),
    .secondRamPage(secondRamPage), .ramWrData(ramWrData), .sensorMuxCfgSel(muxSel),
    .analogSetupCfgSel(anaSel), .compensationDacCfgSel(compSel), .ramReservedSel(resSel));
  register_host_model host (.clock(clock), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdHit(regRdHit));
  // Free-running 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Counts and reports one comparison
  task automatic check(input string what, input logic [7:0] seenV, input logic [7:0] expV);
    nChecks++;
    if (seenV !== expV) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, expV, seenV);
    end
  endtask
  // Verdict and end of run
  task automatic stopTest;
    if (failCount == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Measures cycles from the light turning on to the settle pulse
  task automatic settle(input logic [7:0] cnt);
    host.writeReg(8'h3D, cnt);
    illumActive = 1'b1;
    n = 0;
    while (ledSettleDone !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    illumActive = 1'b0;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    {irqRequest, measDoneFlag, measActiveFlag, illumActive, extLevel} = 5'h00;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    check("drive off", 8'(auxPinDriveEnN), 8'h01);
    for (int i = 0; i < 4; i++) begin
      host.readReg(i < 2 ? 8'h3D + 8'(i) : 8'h68 + 8'(i), d, h);
      check("reset value", d, 8'h00);
    end
    for (int i = 0; i < 4; i++) host.writeReg(i < 2 ? 8'h3D + 8'(i) : 8'h68 + 8'(i), 8'hFF);
    repeat (4) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      host.readReg(i < 2 ? 8'h3D + 8'(i) : 8'h68 + 8'(i), d, h);
      check("stored bits", d, i == 0 ? 8'hFF : i == 1 ? 8'h7F : i == 2 ? 8'h9F : 8'h0E);
    end
    host.readReg(8'h00, d, h);
    check("unmapped", {d[7:1], h}, 8'h00);
    host.writeReg(8'h6B, 8'h00);
    host.writeReg(8'h3D, 8'h00);
    for (int c = 0; c < 16; c++) begin
      src = c[0] ? 4'b1010 : 4'b0101;
      {illumActive, measActiveFlag, measDoneFlag, irqRequest} = src;
      host.writeReg(8'h3E, {1'b0, 3'(c / 2), c[0], 3'(c / 2)});
      @(posedge clock);
      #1;
      x = (c / 2 < 4) ? src[c / 2] : 1'b0;
      check("irq pin", 8'(irqOutPin), 8'(x ^ c[0]));
      check("aux pin", 8'(auxPinOut), 8'(c < 2 ? 1'b0 : x));
    end
    {illumActive, measActiveFlag, measDoneFlag, irqRequest} = 4'h0;
    host.writeReg(8'h3E, 8'h00);
    extLevel = 1'b1;
    for (int i = 0; i < 3; i++) begin
      host.writeReg(8'h6B, i == 0 ? 8'h0B : i == 1 ? 8'h06 : 8'h0E);
      repeat (3) @(posedge clock);
      host.readReg(8'h6B, d, h);
      check("pin control", d, i == 0 ? 8'h0A : i == 1 ? 8'h07 : 8'h0F);
      check("pin drive", {auxPinDriveEnN, auxPinOut}, i == 0 ? 8'h02 : i == 1 ? 8'h01 : 8'h00);
    end
    host.writeReg(8'h6A, 8'h8A);
    host.writeReg(8'h43, 8'h55);
    check("window write", {ramWrEn, secondRamPage, 1'b0, ramLocation}, 8'hCD);
    check("window data", ramWrData, 8'h55);
    check("mux select", 8'(muxSel), 8'h02);
    for (int o = 11; o < 20; o++) begin
      host.writeReg(8'h6A, 8'(o));
      host.readReg(8'h40, d, h);
      e = (o >= 12 && o < 16) ? 8'h10 << (o - 12) : o == 16 ? 8'h04 : o == 17 ? 8'h08 :
        o == 18 ? 8'h02 : 8'h01;
      check("ram select", {muxSel, anaSel, compSel, resSel}, e);
      check("window read", {ramRdEn, h, 1'b0, ramLocation}, 8'h80 | 8'(o));
    end
    host.writeReg(8'h6A, 8'h1F);
    host.writeReg(8'h5F, 8'hAA);
    check("window wrap", {ramWrEn, secondRamPage, 1'b0, ramLocation}, 8'h9E);
    for (int i = 0; i < 3; i++) begin
      settle(8'(i * i));
      check("settle span", 8'(n >= i * i * UNIT + 2 && n <= i * i * UNIT + 4), 8'h01);
    end
    host.writeReg(8'h3D, 8'h03);
    illumActive = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check("settle busy", 8'(ledSettleBusy), 8'h01);
    illumActive = 1'b0;
    seen = 1'b0;
    repeat (20) begin
      @(posedge clock);
      #1;
      seen = seen | ledSettleDone;
    end
    check("aborted wait", {ledSettleBusy, seen}, 8'h00);
    stopTest();
  end
  // Watchdog well beyond the expected span
  initial begin
    #2000000;
    failCount++;
    stopTest();
  end
endmodule
`default_nettype wire
